// ===== logic/blm_master.sv
/*
  Controller end of the link: polls the boiler data points, clamps limits,
  watches the link, decodes faults and runs minimum-charge control.
  Assumes the slave answers within sixteen cycles of each request.
*/
`timescale 1ns/1ps
// Summary of operation
// - Frames carry only the extended protocol variant
// - Per-point valid flag gates dependent functions
// - Clamp own limits to boiler minimum/maximum
// - Night setpoint off disables hot-water charging
// - Report fault codes one to six, timestamped
// - Sixty seconds silent: link broken, red
// - Interlock code only when fault bit set
// - Status low bit1: heating control active
// - Status high bit1: heating requirement on
// - Heating setpoint acts only under requirement
// - Separate points: modulation limit, actual modulation
// - Short burn under demand enters minimum charge
// - Block with zero setpoint ten minutes
// - Then maximum request until flame returns
// - Short run again blocks; else end
// - Enter when flame off, release on, demand
// - Capacity control through modulation limit point
// - Blocking clears requirement, setpoint at minimum
// - No modulation: flame, then setpoint minus one
// - Modulation start: requirement, zero limit, maximum
// - Back to temperature after full cycle burn
// - Boiler self-balancing disables own algorithm
// - Status never written; flags ride read frame
module blm_master #(
  parameter int unsigned TICK_CYCLES = blm_pkg::TICK_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Link
  blm_link_if.master link,
  // Controller settings
  input wire logic link_mode_i,
  input wire logic timers_clear_i,
  input wire logic mod_ctl_i,
  input wire logic [7:0] demand_i,
  input wire logic [7:0] capacity_i,
  input wire logic [7:0] hw_night_i,
  input wire logic [15:0] cycle_s_i,
  // Status
  output logic link_broken_o,
  output logic led_red_o,
  output logic [7:0] fault_code_o,
  output logic [15:0] fault_stamp_o,
  output logic fault_new_o,
  output logic [7:0] interlock_o,
  output logic mc_active_o,
  output logic hw_enable_o,
  output logic [7:0] hw_sp_o,
  output logic [7:0] sp_sent_o,
  output logic [7:0] mod_sent_o,
  output logic [7:0] points_valid_o
);
  typedef struct packed {
    logic req_valid;
    logic req_write;
    logic [7:0] req_id;
    logic [15:0] req_data;
    logic busy;
    logic [3:0] wait_cnt;
    logic [2:0] idx;
    logic [24:0] tick_cnt;
    logic [15:0] secs;
    logic [15:0] idle_s;
    logic [7:0] valid;
    logic [7:0] st_lb;
    logic [7:0] cfg_hb;
    logic [15:0] fault_word;
    logic [7:0] bmin;
    logic [7:0] bmax;
    logic [7:0] hwmin;
    logic [7:0] hwmax;
    blm_pkg::blm_mc_state_t mc;
    logic mc_act;
    logic [15:0] mc_timer;
    logic [15:0] flame_run;
    logic flame_d;
    logic short_burn;
    logic req_bit;
    logic [7:0] sp;
    logic [7:0] mod;
    logic broken;
    logic [7:0] fault_code;
    logic [15:0] fault_stamp;
    logic fault_new;
    logic [7:0] interlock;
    logic hw_en;
    logic [7:0] hw_sp;
  } blm_mst_t;

  blm_mst_t st, next_st;
  logic tick;
  logic flame;
  logic mc_allow;
  logic [7:0] dem;
  logic [7:0] max_req;
  logic [15:0] done_s;

  // Poll list: index to data point
  function automatic logic [7:0] poll_id(input logic [2:0] i);
    case (i)
      3'h0: poll_id = blm_pkg::ID_STATUS;
      3'h1: poll_id = blm_pkg::ID_CH_SP;
      3'h2: poll_id = blm_pkg::ID_MOD_LIMIT;
      3'h3: poll_id = blm_pkg::ID_SLV_CFG;
      3'h4: poll_id = blm_pkg::ID_FAULT;
      3'h5: poll_id = blm_pkg::ID_MOD_ACT;
      3'h6: poll_id = blm_pkg::ID_CH_BOUNDS;
      default: poll_id = blm_pkg::ID_HW_BOUNDS;
    endcase
  endfunction

  function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lo,
                                       input logic [7:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  always_comb begin
    next_st = st;
    next_st.req_valid = 1'b0;
    next_st.fault_new = 1'b0;
    flame = st.st_lb[blm_pkg::ST_LB_FLAME];
    // Only after the bounds arrived are they trusted
    dem = st.valid[6] ? clamp(demand_i, st.bmin, st.bmax) : demand_i;
    max_req = st.valid[6] ? st.bmax : blm_pkg::MAX_REQ_C;
    mc_allow = st.valid[0] && st.valid[3] && !st.cfg_hb[blm_pkg::CFG_HB_SELF_BAL];
    done_s = (cycle_s_i > 16'(blm_pkg::MIN_RUN_S)) ? cycle_s_i : 16'(blm_pkg::MIN_RUN_S);

    // One-second tick and second counters
    tick = (st.tick_cnt == 25'(TICK_CYCLES - 1));
    next_st.tick_cnt = tick ? 25'h0 : st.tick_cnt + 25'h1;
    if (tick) begin
      next_st.secs = st.secs + 16'h1;
      if (st.idle_s < 16'(blm_pkg::LINK_TIMEOUT_S)) begin
        next_st.idle_s = st.idle_s + 16'h1;
      end
      if (flame && st.flame_run != 16'hffff) begin
        next_st.flame_run = st.flame_run + 16'h1;
      end
      next_st.mc_timer = st.mc_timer + 16'h1;
    end
    next_st.flame_d = flame;
    if (st.flame_d && !flame) begin
      next_st.short_burn = st.flame_run < 16'(blm_pkg::MIN_RUN_S);
      next_st.flame_run = 16'h0;
    end

    // Polling engine
    if (!st.busy) begin
      next_st.req_valid = 1'b1;
      next_st.busy = 1'b1;
      next_st.wait_cnt = 4'h0;
      next_st.req_id = poll_id(st.idx);
      // Status goes as a read carrying our flags
      next_st.req_write = (poll_id(st.idx) == blm_pkg::ID_CH_SP) ||
                          (poll_id(st.idx) == blm_pkg::ID_MOD_LIMIT);
      case (poll_id(st.idx))
        blm_pkg::ID_STATUS: next_st.req_data = {6'h00, st.req_bit, 1'b0, 8'h00};
        blm_pkg::ID_CH_SP: next_st.req_data = {st.sp, 8'h00};
        blm_pkg::ID_MOD_LIMIT: next_st.req_data = {st.mod, 8'h00};
        default: next_st.req_data = 16'h0000;
      endcase
    end else if (link.rsp_valid || st.wait_cnt == blm_pkg::RSP_WAIT_LAST) begin
      next_st.busy = 1'b0;
      next_st.idx = (st.idx == blm_pkg::POLL_LAST) ? 3'h0 : st.idx + 3'h1;
      if (link.rsp_valid && link.rsp_ok) begin
        next_st.valid[st.idx] = 1'b1;
        next_st.idle_s = 16'h0;
        case (st.req_id)
          blm_pkg::ID_STATUS: next_st.st_lb = link.rsp_data[7:0];
          blm_pkg::ID_SLV_CFG: next_st.cfg_hb = link.rsp_data[15:8];
          blm_pkg::ID_FAULT: begin
            next_st.fault_word = link.rsp_data;
            if (link.rsp_data[15:8] >= blm_pkg::FAULT_FIRST &&
                link.rsp_data[15:8] <= blm_pkg::FAULT_LAST) begin
              if (link.rsp_data[15:8] != st.fault_code) begin
                next_st.fault_new = 1'b1;
                next_st.fault_stamp = st.secs;
              end
              next_st.fault_code = link.rsp_data[15:8];
            end else begin
              next_st.fault_code = 8'h00;
            end
          end
          blm_pkg::ID_CH_BOUNDS: begin
            next_st.bmax = link.rsp_data[15:8];
            next_st.bmin = link.rsp_data[7:0];
          end
          blm_pkg::ID_HW_BOUNDS: begin
            next_st.hwmax = link.rsp_data[15:8];
            next_st.hwmin = link.rsp_data[7:0];
          end
          default: next_st.busy = 1'b0;
        endcase
      end
    end else begin
      next_st.wait_cnt = st.wait_cnt + 4'h1;
    end

    // Minimum-charge control
    case (st.mc)
      blm_pkg::BLM_MC_NORMAL: begin
        if (mc_allow && st.short_burn && !flame && st.st_lb[blm_pkg::ST_LB_CH_ACTIVE] &&
            dem > st.bmin) begin
          next_st.mc = blm_pkg::BLM_MC_BLOCK;
          next_st.mc_timer = 16'h0;
          next_st.short_burn = 1'b0;
        end
      end
      blm_pkg::BLM_MC_BLOCK: begin
        if (st.mc_timer >= 16'(blm_pkg::BLOCK_S)) begin
          next_st.mc = blm_pkg::BLM_MC_START;
        end
      end
      blm_pkg::BLM_MC_START: begin
        if (flame) begin
          next_st.mc = blm_pkg::BLM_MC_RUN;
        end
      end
      blm_pkg::BLM_MC_RUN: begin
        if (!flame) begin
          next_st.mc = (st.flame_run < 16'(blm_pkg::MIN_RUN_S)) ? blm_pkg::BLM_MC_BLOCK
                                                                : blm_pkg::BLM_MC_NORMAL;
          next_st.mc_timer = 16'h0;
          next_st.short_burn = 1'b0;
        end else if (st.flame_run >= done_s) begin
          next_st.mc = blm_pkg::BLM_MC_NORMAL;
        end
      end
      default: next_st.mc = blm_pkg::BLM_MC_NORMAL;
    endcase
    if (!mc_allow) begin
      next_st.mc = blm_pkg::BLM_MC_NORMAL;
    end
    next_st.mc_act = (next_st.mc != blm_pkg::BLM_MC_NORMAL);
    if (timers_clear_i) begin
      next_st.tick_cnt = 25'h0;
      next_st.idle_s = 16'h0;
      next_st.mc_timer = 16'h0;
      next_st.flame_run = 16'h0;
    end

    // Commands sent on the next poll round
    case (st.mc)
      blm_pkg::BLM_MC_BLOCK: begin
        next_st.req_bit = 1'b0;
        next_st.sp = blm_pkg::SP_MIN_C;
        next_st.mod = blm_pkg::MOD_FULL;
      end
      blm_pkg::BLM_MC_START: begin
        next_st.req_bit = 1'b1;
        next_st.sp = max_req;
        next_st.mod = mod_ctl_i ? blm_pkg::MOD_ZERO : blm_pkg::MOD_FULL;
      end
      blm_pkg::BLM_MC_RUN: begin
        next_st.req_bit = 1'b1;
        // Minus one kelvin keeps the burner on its lowest stage
        next_st.sp = (mod_ctl_i || dem == 8'h00) ? dem : dem - 8'h01;
        next_st.mod = mod_ctl_i ? capacity_i : blm_pkg::MOD_FULL;
      end
      default: begin
        next_st.req_bit = (dem != 8'h00);
        next_st.sp = dem;
        next_st.mod = blm_pkg::MOD_FULL;
      end
    endcase

    next_st.broken = link_mode_i && (st.idle_s >= 16'(blm_pkg::LINK_TIMEOUT_S));
    next_st.interlock = st.st_lb[blm_pkg::ST_LB_FAULT] ? st.fault_word[7:0] : 8'h00;
    next_st.hw_en = (hw_night_i != blm_pkg::HW_SP_OFF);
    next_st.hw_sp = st.valid[7] ? clamp(hw_night_i, st.hwmin, st.hwmax) : hw_night_i;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign link.req_valid = st.req_valid;
  assign link.req_ext = blm_pkg::PROTO_EXT;
  assign link.req_write = st.req_write;
  assign link.req_id = st.req_id;
  assign link.req_data = st.req_data;
  assign link_broken_o = st.broken;
  assign led_red_o = st.broken;
  assign fault_code_o = st.fault_code;
  assign fault_stamp_o = st.fault_stamp;
  assign fault_new_o = st.fault_new;
  assign interlock_o = st.interlock;
  assign mc_active_o = st.mc_act;
  assign hw_enable_o = st.hw_en;
  assign hw_sp_o = st.hw_sp;
  assign sp_sent_o = st.sp;
  assign mod_sent_o = st.mod;
  assign points_valid_o = st.valid;
endmodule

// ===== logic/blm_pkg.sv
/*
  Shared constants and types of the boiler link: data point codes, status
  bit positions, timing figures and the minimum-charge states.
  Assumes a 25 MHz system clock on both ends.
*/
package blm_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_CYCLES_DEF = CLK_HZ * TICK_S;
  localparam int unsigned LINK_TIMEOUT_S = 60;
  localparam int unsigned MIN_RUN_MIN = 8;
  localparam int unsigned MIN_RUN_S = MIN_RUN_MIN * 60;
  localparam int unsigned BLOCK_MIN = 10;
  localparam int unsigned BLOCK_S = BLOCK_MIN * 60;
  localparam logic [3:0] RSP_WAIT_LAST = 4'hf;
  localparam logic [2:0] POLL_LAST = 3'h7;

  // Data point codes
  localparam logic [7:0] ID_STATUS = 8'h00;
  localparam logic [7:0] ID_CH_SP = 8'h01;
  localparam logic [7:0] ID_SLV_CFG = 8'h03;
  localparam logic [7:0] ID_FAULT = 8'h05;
  localparam logic [7:0] ID_MOD_LIMIT = 8'h0e;
  localparam logic [7:0] ID_MOD_ACT = 8'h11;
  localparam logic [7:0] ID_HW_BOUNDS = 8'h30;
  localparam logic [7:0] ID_CH_BOUNDS = 8'h31;

  // Status and configuration bit positions
  localparam int unsigned ST_LB_FAULT = 0;
  localparam int unsigned ST_LB_CH_ACTIVE = 1;
  localparam int unsigned ST_LB_FLAME = 3;
  localparam int unsigned ST_HB_CH_REQ = 1;
  localparam int unsigned CFG_HB_SELF_BAL = 4;

  // Values in whole degrees or percent, fault code range and protocol variant
  localparam logic [7:0] MAX_REQ_C = 8'h78;
  localparam logic [7:0] SP_MIN_C = 8'h00;
  localparam logic [7:0] HW_SP_OFF = 8'h00;
  localparam logic [7:0] MOD_ZERO = 8'h00;
  localparam logic [7:0] MOD_FULL = 8'h64;
  localparam logic [7:0] FAULT_FIRST = 8'h01;
  localparam logic [7:0] FAULT_LAST = 8'h06;
  localparam logic PROTO_EXT = 1'b1;

  typedef enum logic [1:0] {
    BLM_MC_NORMAL = 2'b00,
    BLM_MC_BLOCK = 2'b01,
    BLM_MC_START = 2'b11,
    BLM_MC_RUN = 2'b10
  } blm_mc_state_t;
endpackage

// ===== logic/blm_link_if.sv
/*
  Frame-level link between controller (master) and boiler unit (slave).
  Requests and answers are one-cycle pulses on the common clock.
*/
`timescale 1ns/1ps
interface blm_link_if;
  logic req_valid;
  logic req_ext;
  logic req_write;
  logic [7:0] req_id;
  logic [15:0] req_data;
  logic rsp_valid;
  logic rsp_ok;
  logic [15:0] rsp_data;

  modport master (
    output req_valid, req_ext, req_write, req_id, req_data,
    input rsp_valid, rsp_ok, rsp_data
  );
  modport slave (
    input req_valid, req_ext, req_write, req_id, req_data,
    output rsp_valid, rsp_ok, rsp_data
  );
endinterface

// ===== logic/blm_slave.sv
/*
  Boiler end of the link: answers each request one cycle after it,
  stores the written setpoint, modulation limit and master status flags.
  Assumes the master waits for an answer before the next request.
*/
`timescale 1ns/1ps
module blm_slave (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Link
  blm_link_if.slave link,
  // Boiler state
  input wire logic flame_i,
  input wire logic fault_ind_i,
  input wire logic ch_active_i,
  input wire logic self_balance_i,
  input wire logic [15:0] fault_word_i,
  input wire logic [7:0] mod_act_i,
  input wire logic [7:0] ch_min_i,
  input wire logic [7:0] ch_max_i,
  input wire logic [7:0] hw_min_i,
  input wire logic [7:0] hw_max_i,
  // Commands seen
  output logic ch_req_o,
  output logic [7:0] ch_sp_o,
  output logic [7:0] mod_limit_o
);
  typedef struct packed {
    logic rsp_valid;
    logic rsp_ok;
    logic [15:0] rsp_data;
    logic [7:0] master_hb;
    logic [7:0] sp;
    logic [7:0] mod;
    logic [7:0] sp_eff;
  } blm_slv_t;

  blm_slv_t st, next_st;
  logic [7:0] lb;

  always_comb begin
    next_st = st;
    lb = 8'h00;
    lb[blm_pkg::ST_LB_FAULT] = fault_ind_i;
    lb[blm_pkg::ST_LB_CH_ACTIVE] = ch_active_i;
    lb[blm_pkg::ST_LB_FLAME] = flame_i;
    next_st.rsp_valid = 1'b0;
    next_st.rsp_ok = 1'b0;
    next_st.rsp_data = 16'h0000;
    if (link.req_valid) begin
      next_st.rsp_valid = 1'b1;
      // Only extended-variant frames are served
      next_st.rsp_ok = (link.req_ext == blm_pkg::PROTO_EXT);
      if (link.req_ext == blm_pkg::PROTO_EXT) begin
        case (link.req_id)
          blm_pkg::ID_STATUS: begin
            // Master flags ride in the read frame; a write is refused
            next_st.rsp_ok = !link.req_write;
            if (!link.req_write) begin
              next_st.master_hb = link.req_data[15:8];
              next_st.rsp_data = {link.req_data[15:8], lb};
            end
          end
          blm_pkg::ID_CH_SP: begin
            if (link.req_write) begin
              next_st.sp = link.req_data[15:8];
            end
            next_st.rsp_data = {st.sp, 8'h00};
          end
          blm_pkg::ID_MOD_LIMIT: begin
            if (link.req_write) begin
              next_st.mod = link.req_data[15:8];
            end
            next_st.rsp_data = {st.mod, 8'h00};
          end
          blm_pkg::ID_SLV_CFG: begin
            next_st.rsp_data = {3'h0, self_balance_i, 12'h000};
          end
          blm_pkg::ID_FAULT: next_st.rsp_data = fault_word_i;
          blm_pkg::ID_MOD_ACT: next_st.rsp_data = {mod_act_i, 8'h00};
          blm_pkg::ID_CH_BOUNDS: next_st.rsp_data = {ch_max_i, ch_min_i};
          blm_pkg::ID_HW_BOUNDS: next_st.rsp_data = {hw_max_i, hw_min_i};
          default: next_st.rsp_ok = 1'b0;
        endcase
      end
    end
    // Setpoint acts only while the requirement is on
    next_st.sp_eff = next_st.master_hb[blm_pkg::ST_HB_CH_REQ] ? next_st.sp
                                                               : blm_pkg::SP_MIN_C;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign link.rsp_valid = st.rsp_valid;
  assign link.rsp_ok = st.rsp_ok;
  assign link.rsp_data = st.rsp_data;
  assign ch_req_o = st.master_hb[blm_pkg::ST_HB_CH_REQ];
  assign ch_sp_o = st.sp_eff;
  assign mod_limit_o = st.mod;
endmodule

// ===== verif/blm_link_monitor.sv
/*
  Assertions on the frames that pass between the controller and boiler ends.
  Assumes both ends share clk_i and reset_n_i and are joined by one link.
*/
`timescale 1ns/1ps
module blm_link_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Request side
  input wire logic req_valid,
  input wire logic req_ext,
  input wire logic req_write,
  input wire logic [7:0] req_id,
  input wire logic [15:0] req_data,
  // Answer side
  input wire logic rsp_valid,
  input wire logic rsp_ok,
  input wire logic [15:0] rsp_data
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  ext_variant_only_a: assert property (req_valid |-> req_ext)
    else $error("request without extended variant");
  status_read_only_a: assert property (
    req_valid && req_id == blm_pkg::ID_STATUS |-> !req_write)
    else $error("status point sent as write");
  write_points_a: assert property (req_valid && req_write |->
    (req_id == blm_pkg::ID_CH_SP || req_id == blm_pkg::ID_MOD_LIMIT))
    else $error("write to a point that is never written");
  answer_next_a: assert property (req_valid |=> rsp_valid && rsp_ok)
    else $error("request not answered correctly one cycle later");
  no_stray_answer_a: assert property (rsp_valid |-> $past(req_valid))
    else $error("answer without request");
  request_gap_a: assert property (req_valid |=> !req_valid [*2])
    else $error("requests closer than three cycles");
  flags_echo_a: assert property (
    req_valid && req_id == blm_pkg::ID_STATUS |=> rsp_data[15:8] == $past(req_data[15:8]))
    else $error("status read lost the controller flags");
  quiet_answer_a: assert property (!rsp_valid |-> rsp_data == 16'h0000 && !rsp_ok)
    else $error("answer lines busy outside an answer");

  cover property (req_valid && req_id == blm_pkg::ID_STATUS && req_data[9]);
  cover property (req_valid && req_write && req_id == blm_pkg::ID_CH_SP);
  cover property (req_valid && req_write && req_id == blm_pkg::ID_MOD_LIMIT);
  cover property (rsp_valid && rsp_data[15:8] != 8'h00 && $past(req_id) == blm_pkg::ID_FAULT);
endmodule

// ===== verif/test_boiler_link_min_charge_master.sv
/*
  Bench: controller and boiler ends joined by one link, plus a second
  controller facing a boiler that never answers.
  Assumes a 25 MHz clock; the second tick is shortened to ten cycles.
*/
`timescale 1ns/1ps
module test_boiler_link_min_charge_master;
  localparam int unsigned TICK = 10;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic link_mode_i = 1'b1;
  logic link_mode_b = 1'b1;
  logic timers_clear_i = 1'b0;
  logic mod_ctl_i = 1'b1;
  logic [7:0] demand_i = 8'h32;
  logic [7:0] capacity_i = 8'h28;
  logic [7:0] hw_night_i = 8'h00;
  logic [15:0] cycle_s_i = 16'h01f4;
  logic flame_i = 1'b0;
  logic fault_ind_i = 1'b0;
  logic ch_active_i = 1'b1;
  logic self_balance_i = 1'b0;
  logic [15:0] fault_word_i = 16'h0000;
  logic [7:0] mod_act_i = 8'h00;
  logic [7:0] ch_min_i = 8'h1e;
  logic [7:0] ch_max_i = 8'h5a;
  logic [7:0] hw_min_i = 8'h28;
  logic [7:0] hw_max_i = 8'h41;
  logic link_broken_o, led_red_o, fault_new_o, mc_active_o, hw_enable_o, broken_b, red_b;
  logic ch_req_o;
  logic [7:0] fault_code_o, interlock_o, hw_sp_o, sp_sent_o, mod_sent_o, points_valid_o;
  logic [7:0] ch_sp_o, mod_limit_o, r;
  logic [15:0] fault_stamp_o;
  logic [7:0] exp_q[$];
  logic [7:0] last_code = 8'h00;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int seed = 91732;
  int k;

  blm_link_if link ();
  blm_link_if link_b ();

  blm_master #(.TICK_CYCLES(TICK)) i_blm_master (.clk_i, .reset_n_i, .link(link), .link_mode_i,
    .timers_clear_i, .mod_ctl_i, .demand_i, .capacity_i, .hw_night_i, .cycle_s_i,
    .link_broken_o, .led_red_o, .fault_code_o, .fault_stamp_o, .fault_new_o, .interlock_o,
    .mc_active_o, .hw_enable_o, .hw_sp_o, .sp_sent_o, .mod_sent_o, .points_valid_o);
  blm_master #(.TICK_CYCLES(TICK)) i_blm_master_b (.clk_i, .reset_n_i, .link(link_b),
    .link_mode_i(link_mode_b), .timers_clear_i, .mod_ctl_i, .demand_i, .capacity_i,
    .hw_night_i, .cycle_s_i, .link_broken_o(broken_b), .led_red_o(red_b), .fault_code_o(),
    .fault_stamp_o(), .fault_new_o(), .interlock_o(), .mc_active_o(), .hw_enable_o(),
    .hw_sp_o(), .sp_sent_o(), .mod_sent_o(), .points_valid_o());
  blm_slave i_blm_slave (.clk_i, .reset_n_i, .link(link), .flame_i, .fault_ind_i, .ch_active_i,
    .self_balance_i, .fault_word_i, .mod_act_i, .ch_min_i, .ch_max_i, .hw_min_i, .hw_max_i,
    .ch_req_o, .ch_sp_o, .mod_limit_o);
  blm_link_monitor i_blm_link_monitor (.clk_i, .reset_n_i, .req_valid(link.req_valid),
    .req_ext(link.req_ext), .req_write(link.req_write), .req_id(link.req_id),
    .req_data(link.req_data), .rsp_valid(link.rsp_valid), .rsp_ok(link.rsp_ok),
    .rsp_data(link.rsp_data));

  always #20 clk_i = ~clk_i;

  // Silent boiler: answer lines float, so the data toggles instead of holding
  initial begin
    link_b.rsp_valid = 1'b0;
    link_b.rsp_ok = 1'b0;
    link_b.rsp_data = 16'h5a5a;
    forever @(posedge clk_i) link_b.rsp_data <= ~link_b.rsp_data;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_sp(input logic [7:0] v, input int lim);
    int i;
    for (i = 0; i < lim && sp_sent_o !== v; i++) step(1);
  endtask

  task automatic wait_mc(input logic v, input int lim);
    int i;
    for (i = 0; i < lim && mc_active_o !== v; i++) step(1);
  endtask

  task automatic tally_and_finish();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      $display("FAIL %0t timeout", $time);
      tally_and_finish();
    end
  end

  // Result watcher; a repeated pulse of one code is taken as a re-report
  always @(posedge clk_i) begin
    #1;
    if (link.req_valid === 1'b1) begin
      chk(link.req_ext, 16'h0001, "variant");
      if (link.req_id === blm_pkg::ID_STATUS) chk(link.req_write, 16'h0000, "id0 write");
    end
    if (fault_new_o === 1'b1) begin
      if (exp_q.size() > 0) last_code = exp_q.pop_front();
      chk(fault_code_o, last_code, "fault code");
      // Seconds since the first active edge, taken one edge before the pulse
      chk(fault_stamp_o, 16'((cyc - 7) / TICK), "stamp");
    end
  end

  initial begin
    mod_act_i = 8'($random(seed));
    step(6);
    reset_n_i = 1'b1;
    step(40);
    chk(points_valid_o, 8'hff, "points");
    step(460);
    chk(broken_b, 1'b0, "early broken");
    step(200);
    chk({red_b, broken_b}, 2'b11, "broken");
    chk({led_red_o, link_broken_o}, 2'b00, "healthy");
    link_mode_b = 1'b0;
    step(3);
    chk(broken_b, 1'b0, "mode off");
    for (k = 1; k <= 7; k++) begin
      fault_word_i = {k[7:0], 8'h00};
      if (k < 7) exp_q.push_back(k[7:0]);
      step(40);
      chk(exp_q.size(), 16'h0000, "fault seen");
      if (k == 7) chk(fault_code_o, 8'h00, "code seven");
      fault_word_i = 16'h0000;
      step(40);
    end
    r = 8'($random(seed));
    fault_word_i = {8'h00, r};
    step(40);
    chk(interlock_o, 8'h00, "interlock hidden");
    fault_ind_i = 1'b1;
    step(40);
    chk(interlock_o, r, "interlock");
    fault_ind_i = 1'b0;
    fault_word_i = 16'h0000;
    hw_night_i = 8'h46;
    step(40);
    chk(hw_sp_o, hw_max_i, "clamp max");
    hw_night_i = 8'h14;
    step(40);
    chk(hw_sp_o, hw_min_i, "clamp min");
    r = 8'h28 + 8'($unsigned($random(seed)) % 26);
    hw_night_i = r;
    step(40);
    chk({hw_enable_o, hw_sp_o}, {1'b1, r}, "in band");
    hw_night_i = 8'h00;
    step(40);
    chk(hw_enable_o, 1'b0, "night off");
    flame_i = 1'b1;
    step(200);
    flame_i = 1'b0;
    wait_mc(1'b1, 100);
    chk(mc_active_o, 1'b1, "mc entry");
    step(60);
    chk(sp_sent_o, 8'h00, "block sp");
    chk({ch_req_o, ch_sp_o}, 9'h000, "block req");
    step(5000);
    chk(sp_sent_o, 8'h00, "still blocked");
    wait_sp(ch_max_i, 1500);
    step(60);
    chk(sp_sent_o, ch_max_i, "start sp");
    chk({ch_req_o, mod_sent_o, mod_limit_o}, 17'h10000, "start mod");
    flame_i = 1'b1;
    wait_sp(demand_i, 100);
    step(60);
    chk(sp_sent_o, demand_i, "run sp");
    chk({mod_sent_o, mod_limit_o}, {2{capacity_i}}, "capacity");
    chk(ch_sp_o, demand_i, "sp in effect");
    step(200);
    flame_i = 1'b0;
    wait_sp(8'h00, 100);
    step(2);
    chk(mc_active_o, 1'b1, "block again");
    mod_ctl_i = 1'b0;
    wait_sp(ch_max_i, 6500);
    flame_i = 1'b1;
    wait_sp(demand_i - 8'h01, 100);
    step(60);
    chk(sp_sent_o, demand_i - 8'h01, "minus one");
    chk(mod_sent_o, blm_pkg::MOD_FULL, "no mod");
    step(4000);
    chk(mc_active_o, 1'b1, "cycle not done");
    wait_mc(1'b0, 1500);
    chk(mc_active_o, 1'b0, "back to temp");
    self_balance_i = 1'b1;
    flame_i = 1'b0;
    step(60);
    flame_i = 1'b1;
    step(200);
    flame_i = 1'b0;
    step(100);
    chk(mc_active_o, 1'b0, "self balance");
    // Held clear keeps the silent link from timing out
    link_mode_b = 1'b1;
    timers_clear_i = 1'b1;
    step(700);
    chk(broken_b, 1'b0, "clear held");
    timers_clear_i = 1'b0;
    step(590);
    chk(broken_b, 1'b0, "recount early");
    step(20);
    chk(broken_b, 1'b1, "recount done");
    tally_and_finish();
  end
endmodule
